// ===== design/rtc_pkg.sv
// shared constants for the bcd time, date and alarm register block
package rtc_pkg;
  // register byte offsets
  localparam logic [7:0] TIME_OFS = 8'h00;
  localparam logic [7:0] DATE_OFS = 8'h04;
  localparam logic [7:0] ALM_TIME_OFS = 8'h08;
  localparam logic [7:0] ALM_DATE_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] CTRL_OFS = 8'h14;
  // implemented-bit masks, everything else reads zero
  localparam logic [31:0] TIME_MASK = 32'h7F7FFF00;
  localparam logic [31:0] DATE_MASK = 32'hFF1F3F07;
  localparam logic [31:0] ALM_DATE_MASK = 32'h001F3F07;
  // reset values
  localparam logic [31:0] TIME_RST = 32'h00000000;
  localparam logic [31:0] DATE_RST = 32'h00000000;
  localparam logic [31:0] ALM_TIME_RST = 32'h00000000;
  localparam logic [31:0] ALM_DATE_RST = 32'h00000000;
  localparam logic CTRL_EN_RST = 1'b0;
  // field positions: time and alarm time
  localparam int HR_TENS_LSB = 28;
  localparam int HR_UNITS_LSB = 24;
  localparam int MIN_TENS_LSB = 20;
  localparam int MIN_UNITS_LSB = 16;
  localparam int SEC_TENS_LSB = 12;
  localparam int SEC_UNITS_LSB = 8;
  // field positions: date and alarm date
  localparam int YR_TENS_LSB = 28;
  localparam int YR_UNITS_LSB = 24;
  localparam int MON_TENS_BIT = 20;
  localparam int MON_UNITS_LSB = 16;
  localparam int DAY_TENS_LSB = 12;
  localparam int DAY_UNITS_LSB = 8;
  localparam int WEEKDAY_INDEX_LSB = 0;
  // status and control bit positions
  localparam int STAT_SYNC_BIT = 0;
  localparam int STAT_ALM_PEND_BIT = 1;
  localparam int CTRL_EN_BIT = 0;
  // timing
  localparam int CLOCK_PERIOD_NS = 8;
  localparam longint SECOND_NS = 1000000000;
  localparam int TICK_CYCLES = int'(SECOND_NS / CLOCK_PERIOD_NS);
  localparam int SYNC_LEAD_NS = 256;
  localparam int SYNC_LEAD_CYCLES = (SYNC_LEAD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int PRESC_W = 27;
endpackage

// ===== design/rtc_bcd_time_date_alarm_regs.sv
// bcd time, date and alarm registers with a one-second calendar counter
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps

module rtc_bcd_time_date_alarm_regs #(
  parameter int TICK_CYCLES = rtc_pkg::TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] time_of_day,
  output logic [31:0] calendar_date,
  output logic [31:0] alarm_time_live,
  output logic [31:0] alarm_date_live,
  output logic sync_busy,
  output logic alarm_update_pending
);

  // ****************************************
  // helper functions
  // ****************************************
  function automatic logic [6:0] bcd2bin(input logic [3:0] tens, input logic [3:0] units);
    // widen before the product: a four-bit product would wrap above 15
    bcd2bin = 7'(tens) * 7'h0A + 7'(units);
  endfunction

  function automatic logic [7:0] bin2bcd(input logic [6:0] v);
    logic [6:0] t;
    t = v / 7'h0A;
    bin2bcd = {t[3:0], 4'(v - 7'(t * 7'h0A))};
  endfunction

  function automatic logic [4:0] month_days(input logic [6:0] mon, input logic [6:0] yr);
    case (mon)
      7'h02: month_days = (yr[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      7'h04, 7'h06, 7'h09, 7'h0B: month_days = 5'h1E;
      default: month_days = 5'h1F;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == rtc_pkg::TIME_OFS) || (a == rtc_pkg::DATE_OFS) ||
             (a == rtc_pkg::ALM_TIME_OFS) || (a == rtc_pkg::ALM_DATE_OFS) ||
             (a == rtc_pkg::STATUS_OFS) || (a == rtc_pkg::CTRL_OFS);
  endfunction

  // ****************************************
  // bus decode
  // ****************************************
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic wr_time;
  logic wr_date;
  logic wr_alm_time;
  logic wr_alm_date;
  logic wr_ctrl;

  // zero wait states; a held-low clock enable stretches the access phase
  assign pready = clk_en;
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign pslverr = access_ph && !mapped(paddr);
  assign wr_en = access_ph && pwrite && clk_en;
  assign wr_time = wr_en && (paddr == rtc_pkg::TIME_OFS);
  assign wr_date = wr_en && (paddr == rtc_pkg::DATE_OFS);
  assign wr_alm_time = wr_en && (paddr == rtc_pkg::ALM_TIME_OFS);
  assign wr_alm_date = wr_en && (paddr == rtc_pkg::ALM_DATE_OFS);
  assign wr_ctrl = wr_en && (paddr == rtc_pkg::CTRL_OFS);

  // ****************************************
  // second prescaler
  // ****************************************
  logic [rtc_pkg::PRESC_W-1:0] presc_r;
  logic ctrl_en_r;
  logic tick;

  assign tick = ctrl_en_r && (presc_r == rtc_pkg::PRESC_W'(TICK_CYCLES - 1));

  // writing the time restarts the second so the new value lasts a full second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      presc_r <= '0;
    end else if (clk_en) begin
      if (!ctrl_en_r || wr_time || tick) begin
        presc_r <= '0;
      end else begin
        presc_r <= presc_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_en_r <= rtc_pkg::CTRL_EN_RST;
    end else if (clk_en && wr_ctrl) begin
      ctrl_en_r <= pwdata[rtc_pkg::CTRL_EN_BIT];
    end
  end

  // ****************************************
  // calendar counting
  // ****************************************
  logic [31:0] time_r;
  logic [31:0] date_r;
  logic [31:0] time_nxt;
  logic [31:0] date_nxt;

  always_comb begin
    logic [6:0] sec;
    logic [6:0] min;
    logic [6:0] hr;
    logic [6:0] day;
    logic [6:0] mon;
    logic [6:0] yr;
    logic [2:0] wd;
    logic day_carry;
    logic [7:0] b;
    day_carry = 1'b0;
    b = 8'h00;
    sec = bcd2bin(time_r[rtc_pkg::SEC_TENS_LSB +: 4], time_r[rtc_pkg::SEC_UNITS_LSB +: 4]);
    min = bcd2bin({1'b0, time_r[rtc_pkg::MIN_TENS_LSB +: 3]},
                  time_r[rtc_pkg::MIN_UNITS_LSB +: 4]);
    hr = bcd2bin({1'b0, time_r[rtc_pkg::HR_TENS_LSB +: 3]}, time_r[rtc_pkg::HR_UNITS_LSB +: 4]);
    day = bcd2bin({2'b00, date_r[rtc_pkg::DAY_TENS_LSB +: 2]},
                  date_r[rtc_pkg::DAY_UNITS_LSB +: 4]);
    mon = bcd2bin({3'b000, date_r[rtc_pkg::MON_TENS_BIT]}, date_r[rtc_pkg::MON_UNITS_LSB +: 4]);
    yr = bcd2bin(date_r[rtc_pkg::YR_TENS_LSB +: 4], date_r[rtc_pkg::YR_UNITS_LSB +: 4]);
    wd = date_r[rtc_pkg::WEEKDAY_INDEX_LSB +: 3];
    // fields whose value after bcd2bin exceeds the top value are caught by these >= compares and wrap like the top value
    if (sec >= 7'd59) begin
      sec = 7'd0;
      if (min >= 7'd59) begin
        min = 7'd0;
        if (hr >= 7'd23) begin
          hr = 7'd0;
          day_carry = 1'b1;
        end else begin
          hr = hr + 7'd1;
        end
      end else begin
        min = min + 7'd1;
      end
    end else begin
      sec = sec + 7'd1;
    end
    if (day_carry) begin
      wd = (wd >= 3'd6) ? 3'd0 : wd + 3'd1;
      if (day >= 7'(month_days(mon, yr))) begin
        day = 7'd1;
        if (mon >= 7'd12) begin
          mon = 7'd1;
          yr = (yr >= 7'd99) ? 7'd0 : yr + 7'd1;
        end else begin
          mon = mon + 7'd1;
        end
      end else begin
        day = day + 7'd1;
      end
    end
    time_nxt = '0;
    b = bin2bcd(hr);
    time_nxt[rtc_pkg::HR_TENS_LSB +: 3] = b[6:4];
    time_nxt[rtc_pkg::HR_UNITS_LSB +: 4] = b[3:0];
    b = bin2bcd(min);
    time_nxt[rtc_pkg::MIN_TENS_LSB +: 3] = b[6:4];
    time_nxt[rtc_pkg::MIN_UNITS_LSB +: 4] = b[3:0];
    b = bin2bcd(sec);
    time_nxt[rtc_pkg::SEC_TENS_LSB +: 4] = b[7:4];
    time_nxt[rtc_pkg::SEC_UNITS_LSB +: 4] = b[3:0];
    date_nxt = '0;
    b = bin2bcd(yr);
    date_nxt[rtc_pkg::YR_TENS_LSB +: 4] = b[7:4];
    date_nxt[rtc_pkg::YR_UNITS_LSB +: 4] = b[3:0];
    b = bin2bcd(mon);
    date_nxt[rtc_pkg::MON_TENS_BIT] = b[4];
    date_nxt[rtc_pkg::MON_UNITS_LSB +: 4] = b[3:0];
    b = bin2bcd(day);
    date_nxt[rtc_pkg::DAY_TENS_LSB +: 2] = b[5:4];
    date_nxt[rtc_pkg::DAY_UNITS_LSB +: 4] = b[3:0];
    date_nxt[rtc_pkg::WEEKDAY_INDEX_LSB +: 3] = wd;
  end

  // software writes beat the tick so a freshly set time is not skipped
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      time_r <= rtc_pkg::TIME_RST;
    end else if (clk_en) begin
      // unimplemented time bits forced to zero
      if (wr_time) begin
        time_r <= pwdata & rtc_pkg::TIME_MASK;
      end else if (tick) begin
        time_r <= time_nxt;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      date_r <= rtc_pkg::DATE_RST;
    end else if (clk_en) begin
      // unimplemented date bits forced to zero
      if (wr_date) begin
        date_r <= pwdata & rtc_pkg::DATE_MASK;
      end else if (tick && !wr_time) begin
        date_r <= date_nxt;
      end
    end
  end

  // ****************************************
  // alarm staging
  // ****************************************
  logic [31:0] alm_time_r;
  logic [31:0] alm_date_r;
  logic [31:0] alm_time_live_r;
  logic [31:0] alm_date_live_r;
  logic alm_pend_r;

  // staged values move to the live copy on a second boundary, or at once while counting is disabled, so the
  // downstream matcher never sees a half-written alarm
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alm_time_r <= rtc_pkg::ALM_TIME_RST;
      alm_date_r <= rtc_pkg::ALM_DATE_RST;
    end else if (clk_en) begin
      // same mask and layout as the time register
      if (wr_alm_time) begin
        alm_time_r <= pwdata & rtc_pkg::TIME_MASK;
      end
      // year and other unused alarm date bits dropped
      if (wr_alm_date) begin
        alm_date_r <= pwdata & rtc_pkg::ALM_DATE_MASK;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alm_pend_r <= 1'b0;
    end else if (clk_en) begin
      // a new write sets the flag and wins over the clear
      if (wr_alm_time || wr_alm_date) begin
        alm_pend_r <= 1'b1;
      end else if (tick || !ctrl_en_r) begin
        alm_pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alm_time_live_r <= rtc_pkg::ALM_TIME_RST;
      alm_date_live_r <= rtc_pkg::ALM_DATE_RST;
    end else if (clk_en && alm_pend_r && !wr_alm_time && !wr_alm_date &&
                 (tick || !ctrl_en_r)) begin
      alm_time_live_r <= alm_time_r;
      alm_date_live_r <= alm_date_r;
    end
  end

  // ****************************************
  // sync indication
  // ****************************************
  logic sync_r;

  // high in the last cycles before a tick and through it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_r <= 1'b0;
    end else if (clk_en) begin
      sync_r <= ctrl_en_r && !wr_time && !tick &&
                (presc_r >= rtc_pkg::PRESC_W'(TICK_CYCLES - 1 - rtc_pkg::SYNC_LEAD_CYCLES - 1));
    end
  end

  // ****************************************
  // read data
  // ****************************************
  logic [31:0] prdata_r;

  // sampled in the setup cycle; access phase returns it with zero wait
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= '0;
    end else if (clk_en && setup_ph) begin
      case (paddr)
        rtc_pkg::TIME_OFS: prdata_r <= time_r;
        rtc_pkg::DATE_OFS: prdata_r <= date_r;
        rtc_pkg::ALM_TIME_OFS: prdata_r <= alm_time_r;
        rtc_pkg::ALM_DATE_OFS: prdata_r <= alm_date_r;
        rtc_pkg::STATUS_OFS: begin
          prdata_r <= '0;
          prdata_r[rtc_pkg::STAT_SYNC_BIT] <= sync_r;
          prdata_r[rtc_pkg::STAT_ALM_PEND_BIT] <= alm_pend_r;
        end
        rtc_pkg::CTRL_OFS: begin
          prdata_r <= '0;
          prdata_r[rtc_pkg::CTRL_EN_BIT] <= ctrl_en_r;
        end
        default: prdata_r <= '0;
      endcase
    end
  end

  assign prdata = prdata_r;
  assign time_of_day = time_r;
  assign calendar_date = date_r;
  assign alarm_time_live = alm_time_live_r;
  assign alarm_date_live = alm_date_live_r;
  assign sync_busy = sync_r;
  assign alarm_update_pending = alm_pend_r;

endmodule

// ===== verification/rtc_regs_assertions.sv
// port checker for the bcd time, date and alarm register block
`timescale 1ns/1ps
module rtc_regs_chk #(
  parameter int TICK_CYCLES = 100
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] time_of_day,
  input wire logic [31:0] calendar_date,
  input wire logic [31:0] alarm_time_live,
  input wire logic [31:0] alarm_date_live,
  input wire logic sync_busy,
  input wire logic alarm_update_pending
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire acc = psel && penable && pready;
  wire wr_time = acc && pwrite && paddr == rtc_pkg::TIME_OFS;
  wire wr_date = acc && pwrite && paddr == rtc_pkg::DATE_OFS;
  wire wr_alm = acc && pwrite &&
    (paddr == rtc_pkg::ALM_TIME_OFS || paddr == rtc_pkg::ALM_DATE_OFS);
  // time moved by the counter, not by software
  sequence tick_s;
    $changed(time_of_day) && !$past(wr_time);
  endsequence
  time_write_a: assert property (wr_time |=>
    time_of_day == ($past(pwdata) & rtc_pkg::TIME_MASK))
    else $error("time write not held");
  date_write_a: assert property (wr_date |=>
    calendar_date == ($past(pwdata) & rtc_pkg::DATE_MASK))
    else $error("date write not held");
  time_zero_a: assert property ((time_of_day & ~rtc_pkg::TIME_MASK) == 32'h00000000)
    else $error("time reserved bits set");
  alm_time_zero_a: assert property ((alarm_time_live & ~rtc_pkg::TIME_MASK) == 32'h00000000)
    else $error("alarm time reserved bits set");
  date_zero_a: assert property ((calendar_date & ~rtc_pkg::DATE_MASK) == 32'h00000000)
    else $error("date reserved bits set");
  alm_date_zero_a: assert property ((alarm_date_live & ~rtc_pkg::ALM_DATE_MASK) == 32'h00000000)
    else $error("alarm date reserved bits set");
  sync_before_a: assert property (tick_s |-> $past(sync_busy))
    else $error("time moved without sync flag");
  alarm_pend_a: assert property (wr_alm |=> alarm_update_pending [*1])
    else $error("alarm write left pending low");
  sec_step_a: assert property (tick_s |-> time_of_day[11:8] ==
    ($past(time_of_day[11:8]) == 4'h9 ? 4'h0 : $past(time_of_day[11:8]) + 4'h1))
    else $error("seconds did not step by one");
  cover property (tick_s);
  cover property (acc && pslverr);
  cover property ($fell(alarm_update_pending));
endmodule

bind rtc_bcd_time_date_alarm_regs rtc_regs_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .time_of_day(time_of_day), .calendar_date(calendar_date),
  .alarm_time_live(alarm_time_live), .alarm_date_live(alarm_date_live),
  .sync_busy(sync_busy), .alarm_update_pending(alarm_update_pending));

// ===== verification/tb_rtc_bcd_time_date_alarm_regs.sv
// self-checking bench for the bcd time, date and alarm register block
`timescale 1ns/1ps
module tb_rtc_bcd_time_date_alarm_regs;
  logic clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, lfsr = 32'h00000051;
  logic [31:0] prdata, time_of_day, calendar_date, alarm_time_live, alarm_date_live;
  logic pready, pslverr, sync_busy, alarm_update_pending;
  logic sync_seen = 1'b0;
  logic [32:0] exp_q[$];
  int n_mismatch = 0, check_count = 0, cyc = 0;
  always #4 clock = ~clock;
  // short second so a rollover fits in the run
  rtc_bcd_time_date_alarm_regs #(.TICK_CYCLES(100)) u_dut (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .time_of_day(time_of_day), .calendar_date(calendar_date),
    .alarm_time_live(alarm_time_live), .alarm_date_live(alarm_date_live),
    .sync_busy(sync_busy), .alarm_update_pending(alarm_update_pending));
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one apb transfer; e is {pslverr, read data}, read data zero for writes
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge clock);
    exp_q.push_back(e);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= w ? d : rnd();
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // reserved bits get random junk, implemented bits a legal value
  task automatic wr_rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    apb(a, 1'b1, v | (rnd() & ~m), 33'h000000000);
    apb(a, 1'b0, 32'h00000000, {1'b0, v});
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      close_out();
    end
    if (rst_n && psel && penable && pready === 1'b1) begin
      check("apb answer", {pslverr, pwrite ? 32'h00000000 : prdata}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    for (int a = 0; a < 28; a += 4) apb(8'(a), 1'b0, 32'h00000000, {a == 24, 32'h0});
    apb(rtc_pkg::CTRL_OFS, 1'b1, 32'h00000001, 33'h000000000);
    wr_rd(rtc_pkg::TIME_OFS, 32'h23595900, rtc_pkg::TIME_MASK);
    wr_rd(rtc_pkg::DATE_OFS, 32'h99123106, rtc_pkg::DATE_MASK);
    wr_rd(rtc_pkg::ALM_TIME_OFS, 32'h12345600, rtc_pkg::TIME_MASK);
    // software keeps every digit in range, so the alarm month is a real one
    wr_rd(rtc_pkg::ALM_DATE_OFS, 32'h00122906, rtc_pkg::ALM_DATE_MASK);
    apb(rtc_pkg::STATUS_OFS, 1'b0, 32'h00000000, 33'h000000002);
    // hold the access phase with the clock enable low
    fork
      begin
        repeat (2) @(posedge clock);
        clk_en <= 1'b0;
        repeat (3) @(posedge clock);
        clk_en <= 1'b1;
      end
      apb(rtc_pkg::CTRL_OFS, 1'b0, 32'h00000000, 33'h000000001);
    join
    // the flag seen at the tick edge must be high, and low one edge later
    for (int i = 0; i < 300 && time_of_day === 32'h23595900; i++) begin
      sync_seen = sync_busy;
      @(posedge clock);
    end
    check("sync before tick", {32'h0, sync_seen}, 33'h000000001);
    check("sync after tick", {32'h0, sync_busy}, 33'h000000000);
    apb(rtc_pkg::TIME_OFS, 1'b0, 32'h00000000, 33'h000000000);
    apb(rtc_pkg::DATE_OFS, 1'b0, 32'h00000000, 33'h000010100);
    apb(rtc_pkg::STATUS_OFS, 1'b0, 32'h00000000, 33'h000000000);
    check("live alarm time", {1'b0, alarm_time_live}, 33'h012345600);
    check("live alarm date", {1'b0, alarm_date_live}, 33'h000122906);
    apb(rtc_pkg::STATUS_OFS, 1'b1, 32'hFFFFFFFF, 33'h000000000);
    apb(rtc_pkg::CTRL_OFS, 1'b1, 32'h00000000, 33'h000000000);
    apb(rtc_pkg::STATUS_OFS, 1'b0, 32'h00000000, 33'h000000000);
    apb(8'h18, 1'b1, rnd(), 33'h100000000);
    repeat (2) @(posedge clock);
    close_out();
  end
endmodule
